// [hdl/cmp_edge_pkg.sv]
package cmp_edge_pkg;

    // Number of comparators in the block
    localparam int unsigned NUM_CMP = 2;

    // APB geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] MODE_A_OFF = 8'h04;
    localparam logic [7:0] MODE_B_OFF = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0C;
    localparam logic [7:0] FLAG_OFF = 8'h10;
    localparam logic [7:0] MASK_OFF = 8'h14;
    localparam logic [7:0] PEND_OFF = 8'h18;

    // Control register fields
    localparam int unsigned CTRL_EN_LSB = 0;
    localparam int unsigned CTRL_SRC_LSB = 8;
    localparam int unsigned CTRL_GIE_BIT = 16;

    // Mode register fields (cmp_mode_reg)
    localparam int unsigned MODE_RISE_BIT = 0;
    localparam int unsigned MODE_FALL_BIT = 1;

    // Status register fields
    localparam int unsigned STAT_OUT_LSB = 0;
    localparam int unsigned STAT_RAWS_LSB = 8;
    localparam int unsigned STAT_EN_LSB = 16;

    // Flag, mask and pending layout: two bits per comparator
    localparam int unsigned FLAG_RISE_SUB = 0;
    localparam int unsigned FLAG_FALL_SUB = 1;
    localparam int unsigned FLAG_STRIDE = 2;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage : cmp_edge_pkg

// [hdl/cmp_sync_edge.sv]
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser, latched output and edge pulses for one comparator
module cmp_sync_edge (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous comparator result
    input wire logic raw_i,
    // Synchronised results
    output logic latched_o,
    output logic rise_o,
    output logic fall_o
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two flops against metastability; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
        end
    end

    // Previous sample for edge compare
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q;
        end
    end

    // Latched output and single-cycle edge pulses
    assign latched_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;

endmodule : cmp_sync_edge

`default_nettype wire

// [hdl/cmp_edge_irq.sv]
// Behaviour
// (R1) An enabled comparator outputs high when the positive input is above the negative input, else low.
// (R2) A disabled comparator outputs a constant low.
// (R3) Each comparator result passes a system-clock synchroniser into a latched output apart from the raw one.
// (R4) The latched output is readable as a status bit, feeds the interrupt logic and goes to the crossbar.
// (R5) The raw output is handed unsynchronised to the wake-up and reset decision logic.
// (R6) The raw output can go straight to a pin and keeps following the inputs with the clock stopped.
// (R7) Interrupts can be raised on rising, falling or both transitions of the output.
// (R8) Each comparator has separate rising-edge and falling-edge flags.
// (R9) A detected edge sets its flag whatever the interrupt enables say.
// (R10) A set flag stays set until software clears it; hardware never clears it.
// (R11) The mode register has separate rising and falling interrupt enables, each gating its own flag.
// (R12) An enabled set flag requests the CPU only with the comparator source enable and global enable set.
// (R13) Edges are found by comparing successive synchronised samples, setting a flag once per transition.
// (R14) Software clears a flag in its service routine; an edge in the clearing cycle keeps the flag set.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module cmp_edge_irq
    import cmp_edge_pkg::*;
#(
    parameter int unsigned N = NUM_CMP
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic [DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Analog comparator decisions, positive above negative
    input wire logic cmp_a_gt_i,
    input wire logic cmp_b_gt_i,
    // Raw outputs to crossbar, wake-up and reset logic
    output logic cmp_a_raw_out_o,
    output logic cmp_b_raw_out_o,
    // Latched outputs to crossbar
    output logic cmp_a_latched_out_o,
    output logic cmp_b_latched_out_o,
    // Interrupt request
    output logic irq_o
);

    localparam int unsigned FW = N * FLAG_STRIDE;

    // Control state
    logic [N-1:0] cmp_en_q;
    logic [N-1:0] src_en_q;
    logic gie_q;
    logic [N-1:0] cmp_rise_irq_en_q;
    logic [N-1:0] cmp_fall_irq_en_q;
    logic [N-1:0] cmp_rise_flag_q;
    logic [N-1:0] cmp_fall_flag_q;

    // Per comparator signals
    logic [N-1:0] gt;
    logic [N-1:0] raw;
    logic [N-1:0] latched;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    logic [N-1:0] raw_sync;
    logic [N-1:0] req;

    // Packed views of flags and enables
    logic [FW-1:0] flag_vec;
    logic [FW-1:0] mask_vec;
    logic [FW-1:0] pend_vec;

    // Bus strobes
    logic setup;
    logic wr_acc;
    logic rd_known;
    logic [DATA_W-1:0] rd_word;
    logic irq_d;

    // Output flops
    logic [N-1:0] latched_out_q;
    logic irq_q;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    assign gt[0] = cmp_a_gt_i;
    assign gt[1] = cmp_b_gt_i;

    // Raw result gated by enable; stays combinational so it works unclocked
    // Deliberately not a flop: wake-up and pin paths must run clockless
    assign raw = gt & cmp_en_q; // see (R1) see (R2) see (R6)

    // Raw paths to pins, wake-up and reset logic
    assign cmp_a_raw_out_o = raw[0]; // see (R5) see (R6)
    assign cmp_b_raw_out_o = raw[1]; // see (R5) see (R6)

    // One synchroniser and edge detector per comparator
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_cmp
            cmp_sync_edge u_sync (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .raw_i(raw[g]),
                .latched_o(latched[g]), // see (R3)
                .rise_o(rise[g]), // see (R13)
                .fall_o(fall[g]) // see (R13)
            );
            assign raw_sync[g] = latched[g];
            assign flag_vec[g*FLAG_STRIDE+FLAG_RISE_SUB] = cmp_rise_flag_q[g];
            assign flag_vec[g*FLAG_STRIDE+FLAG_FALL_SUB] = cmp_fall_flag_q[g];
            assign mask_vec[g*FLAG_STRIDE+FLAG_RISE_SUB] = cmp_rise_irq_en_q[g];
            assign mask_vec[g*FLAG_STRIDE+FLAG_FALL_SUB] = cmp_fall_irq_en_q[g];
            // Each enable gates only its own flag
            assign req[g] = src_en_q[g] &
                ((cmp_rise_flag_q[g] & cmp_rise_irq_en_q[g]) |
                 (cmp_fall_flag_q[g] & cmp_fall_irq_en_q[g])); // see (R11)
        end
    endgenerate

    assign pend_vec = flag_vec & mask_vec;

    // APB phase decode
    assign setup = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pready_q & pwrite_i;

    // Write strobes per register, true at the access edge
    logic wr_ctrl;
    logic wr_flag;
    logic wr_mask;

    assign wr_ctrl = wr_acc && paddr_i == CTRL_OFF;
    assign wr_flag = wr_acc && paddr_i == FLAG_OFF;
    assign wr_mask = wr_acc && paddr_i == MASK_OFF;

    // Known addresses
    always_comb begin
        case (paddr_i)
            CTRL_OFF, MODE_A_OFF, MODE_B_OFF, STATUS_OFF,
            FLAG_OFF, MASK_OFF, PEND_OFF: rd_known = 1'b1;
            default: rd_known = 1'b0;
        endcase
    end

    // Comparator, source and global enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_en_q <= CTRL_RST[CTRL_EN_LSB +: N];
            src_en_q <= CTRL_RST[CTRL_SRC_LSB +: N];
            gie_q <= CTRL_RST[CTRL_GIE_BIT];
        end else if (wr_ctrl) begin
            cmp_en_q <= pwdata_i[CTRL_EN_LSB +: N];
            src_en_q <= pwdata_i[CTRL_SRC_LSB +: N];
            gie_q <= pwdata_i[CTRL_GIE_BIT];
        end
    end

    // Edge interrupt enables per comparator, by mode register or mask alias
    generate
        for (g = 0; g < N; g++) begin : g_mode
            logic wr_mode;

            // Mode registers sit one stride apart from the first one
            assign wr_mode = wr_acc &&
                paddr_i == MODE_A_OFF + 8'(g) * (MODE_B_OFF - MODE_A_OFF);

            // Rising and falling enables; the mask alias writes the same bits
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_rise_irq_en_q[g] <= MODE_RST[MODE_RISE_BIT];
                    cmp_fall_irq_en_q[g] <= MODE_RST[MODE_FALL_BIT];
                end else if (wr_mode) begin
                    cmp_rise_irq_en_q[g] <=
                        pwdata_i[MODE_RISE_BIT]; // see (R7)
                    cmp_fall_irq_en_q[g] <=
                        pwdata_i[MODE_FALL_BIT]; // see (R7)
                end else if (wr_mask) begin
                    cmp_rise_irq_en_q[g] <=
                        pwdata_i[g*FLAG_STRIDE+FLAG_RISE_SUB];
                    cmp_fall_irq_en_q[g] <=
                        pwdata_i[g*FLAG_STRIDE+FLAG_FALL_SUB];
                end
            end
        end
    endgenerate

    // Sticky edge flags per comparator; a one written clears, an edge wins
    generate
        for (g = 0; g < N; g++) begin : g_flag // see (R8)
            logic clr_rise;
            logic clr_fall;

            // Clear requests from a flag register write
            assign clr_rise = wr_flag & pwdata_i[g*FLAG_STRIDE+FLAG_RISE_SUB];
            assign clr_fall = wr_flag & pwdata_i[g*FLAG_STRIDE+FLAG_FALL_SUB];

            // Rising-edge flag; set has priority over a same-cycle clear
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_rise_flag_q[g] <= 1'b0;
                end else if (rise[g]) begin
                    cmp_rise_flag_q[g] <= 1'b1; // see (R9) see (R14)
                end else if (clr_rise) begin
                    cmp_rise_flag_q[g] <= 1'b0; // see (R10)
                end
            end

            // Falling-edge flag; set has priority over a same-cycle clear
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cmp_fall_flag_q[g] <= 1'b0;
                end else if (fall[g]) begin
                    cmp_fall_flag_q[g] <= 1'b1; // see (R9) see (R14)
                end else if (clr_fall) begin
                    cmp_fall_flag_q[g] <= 1'b0; // see (R10)
                end
            end
        end
    endgenerate

    // Latched outputs toward the crossbar
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_out_q <= '0;
        end else begin
            latched_out_q <= latched; // see (R4)
        end
    end

    assign cmp_a_latched_out_o = latched_out_q[0];
    assign cmp_b_latched_out_o = latched_out_q[1];

    // Interrupt request, level, gated by global enable
    assign irq_d = gie_q & (|req); // see (R12)

    // Registered so the request line comes straight from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d; // see (R4)
        end
    end

    assign irq_o = irq_q;

    // APB answer: ready in the first access cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~rd_known;
        end
    end

    // Read word chosen from the address; reserved bits and holes read zero
    always_comb begin
        rd_word = ZERO_WORD;
        case (paddr_i)
            CTRL_OFF: begin
                rd_word[CTRL_EN_LSB +: N] = cmp_en_q;
                rd_word[CTRL_SRC_LSB +: N] = src_en_q;
                rd_word[CTRL_GIE_BIT] = gie_q;
            end
            MODE_A_OFF: begin
                rd_word[MODE_RISE_BIT] = cmp_rise_irq_en_q[0];
                rd_word[MODE_FALL_BIT] = cmp_fall_irq_en_q[0];
            end
            MODE_B_OFF: begin
                rd_word[MODE_RISE_BIT] = cmp_rise_irq_en_q[1];
                rd_word[MODE_FALL_BIT] = cmp_fall_irq_en_q[1];
            end
            STATUS_OFF: begin
                // cmp_out_status bits
                rd_word[STAT_OUT_LSB +: N] = latched_out_q; // see (R4)
                rd_word[STAT_RAWS_LSB +: N] = raw_sync;
                rd_word[STAT_EN_LSB +: N] = cmp_en_q;
            end
            FLAG_OFF: rd_word[FW-1:0] = flag_vec;
            MASK_OFF: rd_word[FW-1:0] = mask_vec;
            PEND_OFF: rd_word[FW-1:0] = pend_vec;
            default: rd_word = ZERO_WORD;
        endcase
    end

    // Read data captured in the setup cycle; writes return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_q <= ZERO_WORD;
        end else if (setup && !pwrite_i) begin
            prdata_q <= rd_word;
        end else if (setup) begin
            prdata_q <= ZERO_WORD;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

endmodule : cmp_edge_irq

`default_nettype wire

// [bench/cmp_edge_irq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// Port-level checks for the comparator edge interrupt block
module cmp_edge_irq_checker
    import cmp_edge_pkg::*;
#(
    parameter int unsigned N = NUM_CMP
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Comparator side
    input wire logic cmp_a_gt_i,
    input wire logic cmp_b_gt_i,
    input wire logic cmp_a_raw_out_o,
    input wire logic cmp_b_raw_out_o,
    input wire logic cmp_a_latched_out_o,
    input wire logic cmp_b_latched_out_o,
    input wire logic irq_o
);
    logic wr_acc;

    // Write access phase in progress
    assign wr_acc = psel_i && penable_i && pwrite_i;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_raw_gate:
        assert property ((cmp_a_raw_out_o |-> cmp_a_gt_i)
            and (cmp_b_raw_out_o |-> cmp_b_gt_i))
        else $error("raw output high without a positive decision");
    chk_latch_lag:
        assert property (cmp_a_latched_out_o == $past(cmp_a_raw_out_o, 3)
            && cmp_b_latched_out_o == $past(cmp_b_raw_out_o, 3))
        else $error("latched output does not trail raw by three cycles");
    chk_irq_hold:
        assert property (irq_o && !wr_acc && !$past(wr_acc) |=> irq_o)
        else $error("interrupt dropped without a register write");
    chk_irq_cause:
        assert property ($rose(irq_o) |-> $past(wr_acc, 2)
            || $past(cmp_a_latched_out_o) != $past(cmp_a_latched_out_o, 2)
            || $past(cmp_b_latched_out_o) != $past(cmp_b_latched_out_o, 2))
        else $error("interrupt rose with no edge and no write");
    chk_ready_slot:
        assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("ready not a single pulse after setup");
    chk_ready_cause:
        assert property (pready_o |-> $past(psel_i && !penable_i)
            && psel_i && penable_i)
        else $error("ready outside an access phase");
    chk_err_map:
        assert property (pready_o && paddr_i[1:0] == 2'h0
            |-> pslverr_o == (paddr_i > PEND_OFF))
        else $error("error response does not match address map");
    chk_err_data:
        assert property (pready_o && pslverr_o && !pwrite_i
            |-> prdata_o == ZERO_WORD)
        else $error("refused read returned nonzero data");
    chk_status_out:
        assert property (pready_o && !pwrite_i && paddr_i == STATUS_OFF
            |-> prdata_o[STAT_OUT_LSB +: 2]
            == {$past(cmp_b_latched_out_o), $past(cmp_a_latched_out_o)})
        else $error("status out bits differ from latched outputs");
endmodule : cmp_edge_irq_checker

bind cmp_edge_irq cmp_edge_irq_checker #(.N(N)) u_cmp_edge_irq_checker (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_a_gt_i(cmp_a_gt_i),
    .cmp_b_gt_i(cmp_b_gt_i), .cmp_a_raw_out_o(cmp_a_raw_out_o),
    .cmp_b_raw_out_o(cmp_b_raw_out_o),
    .cmp_a_latched_out_o(cmp_a_latched_out_o),
    .cmp_b_latched_out_o(cmp_b_latched_out_o), .irq_o(irq_o));

`default_nettype wire

// [bench/cmp_far_side.sv]
`timescale 1ns/1ps
`default_nettype none

// Port crossbar and CPU interrupt intake on the far side
module cmp_far_side (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Comparator results and request
    input wire logic raw_i,
    input wire logic latched_i,
    input wire logic irq_i,
    input wire logic route_raw_i,
    // Pin level and accepted requests
    output logic pin_o,
    output logic [7:0] taken_o
);
    logic irq_q;

    // Crossbar picks raw or latched result for the pin
    assign pin_o = route_raw_i ? raw_i : latched_i;

    // Intake counts each new request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
            taken_o <= 8'h00;
        end else begin
            irq_q <= irq_i;
            if (irq_i && !irq_q) begin
                taken_o <= taken_o + 8'h01;
            end
        end
    end
endmodule : cmp_far_side

`default_nettype wire

// [bench/comparator_output_edge_irq_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module comparator_output_edge_irq_bench;
    import cmp_edge_pkg::*;
    logic clk_i, rst_i, psel_i, penable_i, pwrite_i, gt_a, gt_b, sel;
    logic pready_o, pslverr_o, raw_a, raw_b, lat_a, lat_b, irq_o, err, pin;
    logic [7:0] paddr_i, taken;
    logic [31:0] pwdata_i, prdata_o, rd;
    int mismatches, checks_done;

    cmp_edge_irq u_cmp_edge_irq (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_a_gt_i(gt_a),
        .cmp_b_gt_i(gt_b), .cmp_a_raw_out_o(raw_a), .cmp_b_raw_out_o(raw_b),
        .cmp_a_latched_out_o(lat_a), .cmp_b_latched_out_o(lat_b),
        .irq_o(irq_o));
    cmp_far_side u_cmp_far_side (.clk_i(clk_i), .rst_i(rst_i),
        .raw_i(raw_a), .latched_i(lat_a), .irq_i(irq_o), .route_raw_i(sel),
        .pin_o(pin), .taken_o(taken));

    // Clock, 4 ns period
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // One APB transfer, held until pready is sampled high at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1) mismatches++;
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("prdata", rd, exp);
        check("pslverr", err, a > PEND_OFF);
    endtask : rd_chk

    task automatic t_reset();
        check("raw_a", raw_a, 1'b0);
        rd_chk(CTRL_OFF, CTRL_RST);
        rd_chk(MODE_A_OFF, ZERO_WORD);
        rd_chk(FLAG_OFF, ZERO_WORD);
        rd_chk(8'h1C, ZERO_WORD);
    endtask : t_reset

    task automatic t_edges();
        apb(1'b1, CTRL_OFF, 32'h1);
        gt_a <= 1'b1;
        gt_b <= 1'b1;
        sel <= 1'b1;
        tick(1);
        check("raw_a", raw_a, 1'b1);
        check("raw_b", raw_b, 1'b0);
        check("lat_a", lat_a, 1'b0);
        check("pin", pin, 1'b1);
        sel <= 1'b0;
        tick(1);
        check("pin", pin, 1'b0);
        tick(5);
        check("lat_a", lat_a, 1'b1);
        check("lat_b", lat_b, 1'b0);
        check("pin", pin, 1'b1);
        rd_chk(STATUS_OFF, 32'h0001_0101);
        rd_chk(FLAG_OFF, 32'h1);
        apb(1'b1, FLAG_OFF, 32'h1);
        tick(5);
        rd_chk(FLAG_OFF, 32'h0);
        gt_a <= 1'b0;
        tick(6);
        rd_chk(FLAG_OFF, 32'h2);
        check("irq", irq_o, 1'b0);
    endtask : t_edges

    task automatic t_irq();
        apb(1'b1, FLAG_OFF, 32'hF);
        rd_chk(FLAG_OFF, 32'h0);
        apb(1'b1, CTRL_OFF, 32'h0000_0101);
        apb(1'b1, MODE_A_OFF, 32'h1);
        gt_a <= 1'b1;
        tick(6);
        check("irq", irq_o, 1'b0);
        rd_chk(PEND_OFF, 32'h1);
        apb(1'b1, CTRL_OFF, 32'h0001_0101);
        tick(2);
        check("irq", irq_o, 1'b1);
        gt_a <= 1'b0;
        tick(20);
        check("irq", irq_o, 1'b1);
        apb(1'b1, FLAG_OFF, 32'h1);
        tick(2);
        check("irq", irq_o, 1'b0);
        apb(1'b1, MASK_OFF, 32'h2);
        tick(2);
        check("irq", irq_o, 1'b1);
        rd_chk(MODE_A_OFF, 32'h2);
        check("taken", taken, 8'h02);
        apb(1'b1, FLAG_OFF, 32'hF);
        tick(2);
        check("irq", irq_o, 1'b0);
    endtask : t_irq

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i, gt_a, gt_b, sel} = 6'h00;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        mismatches = 0;
        checks_done = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_edges();
        t_irq();
        give_verdict();
    end
endmodule : comparator_output_edge_irq_bench

`default_nettype wire
